// *** include/khi_pkg.sv ***
// Shared constants and carriers for the keyboard controller host data interface
package khi_pkg;

  // Host offsets at their default base; A2 tells them apart
  localparam logic [7:0] KHI_DATA_OFS       = 8'h60;
  localparam logic [7:0] KHI_STAT_OFS       = 8'h64;
  localparam int         KHI_SEL_BIT        = 2;

  // Status register field positions
  localparam int         KHI_OBF_BIT        = 0;
  localparam int         KHI_IBF_BIT        = 1;
  localparam int         KHI_F0_BIT         = 2;
  localparam int         KHI_CMD_BIT        = 3;
  localparam int         KHI_GP_LO          = 4;
  localparam logic [7:0] KHI_STAT_RST       = 8'h00;
  localparam logic [7:0] KHI_BYTE_RST       = 8'h00;

  // Instruction timing
  localparam int         KHI_CLK_PER_STATE  = 3;
  localparam int         KHI_STATE_PER_CYC  = 5;
  localparam int         KHI_CLK_PER_CYC    = KHI_CLK_PER_STATE * KHI_STATE_PER_CYC;
  localparam logic [1:0] KHI_DIV_LAST       = 2'(KHI_CLK_PER_STATE - 1);
  localparam logic [2:0] KHI_STATE_LAST     = 3'(KHI_STATE_PER_CYC - 1);

  // Output path buffering
  localparam int         KHI_FIFO_W         = 8;
  localparam int         KHI_FIFO_D         = 16;

  // Host bus cycle, one-cycle strobes
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } khi_host_req_t;

  // Firmware side requests
  typedef struct packed {
    logic       ibuf_rd;
    logic       gp_wr;
    logic [3:0] gp;
    logic       f0_clr;
    logic       f0_cpl;
    logic       start;
    logic       two_cyc;
    logic       irq_req;
  } khi_fw_req_t;

  // Firmware side view
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] ibuf;
    logic       ibf_irq;
  } khi_fw_view_t;

  typedef struct packed {
    logic [7:0] obuf;
    logic [7:0] ibuf;
    logic [7:0] status;
    logic [7:0] rdata;
    logic       irq_hold;
    logic       irq_prev;
    logic [1:0] div;
    logic [2:0] st;
    logic       busy;
    logic       two;
    logic       second;
    logic       done;
  } khi_state_t;

endpackage

// *** rtl/khi_host_if.sv ***
// Keyboard controller host data interface with output byte FIFO
`timescale 1ns/100ps
//
// Contract
// - Output byte read-only to host at 60h; host read returns the oldest unread firmware byte.
// - Host write at 60h stores data, flag clear; at 64h command, flag set.
// - Host byte arrival may interrupt firmware; firmware may poll input-full bit 1.
// - Status changes only by hardware and firmware; host writes never write it directly.
// - Output-full sets on firmware buffer write, clears on host buffer read.
// - Input-full sets on every host write, clears on firmware read instruction.
// - Bit 2 general flag, firmware clears or toggles; host cannot touch it.
// - Bit 3 captures A2 on each host write: 1 command, 0 data.
// - Bits 7-4 firmware general flags, untouched by host accesses.
// - Clock divided by 3 into states, five states form a 15-clock cycle.
// - Most instructions take one instruction cycle, some take two.
// - Reads at 64h return status, at 60h the output byte, A2 selects.
// - Latch option holds rising interrupt until host reads output byte, else pass.

////////////////////////////////////////////////////////////////////////////////
module khi_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  // Fill side
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  // Drain side
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);
  localparam int AW = $clog2(D);

  // Count is one bit wider than the pointers so a full queue differs from an empty one
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } khi_fifo_st_t;

  khi_fifo_st_t       fs_reg;
  khi_fifo_st_t       fs_next;
  logic [W-1:0]       mem [D];
  logic               push;
  logic               pop;

  assign o_in_ready  = (fs_reg.cnt != (AW+1)'(D));
  assign o_out_valid = (fs_reg.cnt != '0);
  assign o_out_data  = mem[fs_reg.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    fs_next = fs_reg;
    if (push)
    begin
      fs_next.wp = fs_reg.wp + 1'b1;
    end
    if (pop)
    begin
      fs_next.rp = fs_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   fs_next.cnt = fs_reg.cnt + 1'b1;
      2'b01:   fs_next.cnt = fs_reg.cnt - 1'b1;
      default: fs_next.cnt = fs_reg.cnt;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      fs_reg <= '0;
    end
    else
    begin
      fs_reg <= fs_next;
    end
  end

  // Storage has no reset; only counted words are ever read
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[fs_reg.wp] <= i_in_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking fcb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  fifo_bound_a: assert property (fs_reg.cnt <= (AW+1)'(D))
    else $error("byte queue count beyond depth");
  fifo_head_a: assert property (push && fs_reg.cnt == '0
    |=> o_out_data == $past(i_in_data)) else $error("first queued byte not at head");
  fifo_drain_a: assert property (pop && !push
    |=> fs_reg.cnt == $past(fs_reg.cnt) - 1'b1) else $error("byte queue drain count wrong");

endmodule // khi_fifo

////////////////////////////////////////////////////////////////////////////////
module khi_host_if (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // Host bus
  input  wire khi_pkg::khi_host_req_t i_host,
  output logic [7:0]                 o_host_rdata,
  output logic                       o_host_irq,
  input  wire logic                  i_irq_latch_en,
  // Firmware output byte stream
  input  wire logic                  i_fw_push_valid,
  output logic                       o_fw_push_ready,
  input  wire logic [7:0]            i_fw_push_data,
  // Firmware control and view
  input  wire khi_pkg::khi_fw_req_t  i_fw,
  input  wire logic                  i_ibf_irq_en,
  output khi_pkg::khi_fw_view_t      o_fw,
  // Instruction timing
  output logic                       o_state_tick,
  output logic                       o_cycle_start,
  output logic                       o_instr_done
);
  import khi_pkg::*;

  khi_state_t  s_reg;
  khi_state_t  s_next;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        load;
  logic        host_wr;
  logic        host_rd;
  logic        rd_obuf;
  logic        cyc_end;

  ////////////////////////////////////////////////////////////////////////////
  // Firmware bytes queue here so it need not wait for each host read
  khi_fifo #(
    .W (KHI_FIFO_W),
    .D (KHI_FIFO_D)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_fw_push_valid),
    .o_in_ready  (o_fw_push_ready),
    .i_in_data   (i_fw_push_data),
    .o_out_valid (out_valid),
    .i_out_ready (!s_reg.status[KHI_OBF_BIT]),
    .o_out_data  (out_data)
  );

  assign load    = out_valid && !s_reg.status[KHI_OBF_BIT];
  assign host_wr = i_host.cs && i_host.wr;
  assign host_rd = i_host.cs && i_host.rd;
  assign rd_obuf = host_rd && !i_host.addr[KHI_SEL_BIT];
  assign cyc_end = (s_reg.div == KHI_DIV_LAST) && (s_reg.st == KHI_STATE_LAST);

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    // Host read path
    if (host_rd)
    begin
      s_next.rdata = i_host.addr[KHI_SEL_BIT] ? s_reg.status : s_reg.obuf;
    end
    if (rd_obuf)
    begin
      s_next.status[KHI_OBF_BIT] = 1'b0;
    end
    // Load after the clear so a new byte wins
    if (load)
    begin
      s_next.obuf                = out_data;
      s_next.status[KHI_OBF_BIT] = 1'b1;
    end
    // Firmware read instruction; a host write in the same cycle wins
    if (i_fw.ibuf_rd)
    begin
      s_next.status[KHI_IBF_BIT] = 1'b0;
    end
    if (host_wr)
    begin
      s_next.ibuf                = i_host.wdata;
      s_next.status[KHI_IBF_BIT] = 1'b1;
      s_next.status[KHI_CMD_BIT] = i_host.addr[KHI_SEL_BIT];
    end
    // Only firmware reaches F0 and the upper flags
    if (i_fw.f0_clr)
    begin
      s_next.status[KHI_F0_BIT] = 1'b0;
    end
    else if (i_fw.f0_cpl)
    begin
      s_next.status[KHI_F0_BIT] = !s_reg.status[KHI_F0_BIT];
    end
    if (i_fw.gp_wr)
    begin
      s_next.status[7:KHI_GP_LO] = i_fw.gp;
    end
    // Interrupt latch; a new rising edge beats the read clear
    s_next.irq_prev = i_fw.irq_req;
    if (rd_obuf || !i_irq_latch_en)
    begin
      s_next.irq_hold = 1'b0;
    end
    if (i_irq_latch_en && i_fw.irq_req && !s_reg.irq_prev)
    begin
      s_next.irq_hold = 1'b1;
    end
    // State and instruction cycle dividers
    if (s_reg.div == KHI_DIV_LAST)
    begin
      s_next.div = 2'h0;
      s_next.st  = (s_reg.st == KHI_STATE_LAST) ? 3'h0 : s_reg.st + 3'h1;
    end
    else
    begin
      s_next.div = s_reg.div + 2'h1;
    end
    // Instructions start on a cycle boundary and end on one
    if (!s_reg.busy && i_fw.start && o_cycle_start)
    begin
      s_next.busy   = 1'b1;
      s_next.two    = i_fw.two_cyc;
      s_next.second = 1'b0;
    end
    else if (s_reg.busy && cyc_end)
    begin
      if (s_reg.two && !s_reg.second)
      begin
        s_next.second = 1'b1;
      end
      else
      begin
        s_next.busy = 1'b0;
        s_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s_reg        <= '0;
      s_reg.status <= KHI_STAT_RST;
      s_reg.obuf   <= KHI_BYTE_RST;
      s_reg.ibuf   <= KHI_BYTE_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host writes have no path into status other than the flags above
  assign o_host_rdata   = s_reg.rdata;
  assign o_host_irq     = i_irq_latch_en ? s_reg.irq_hold : i_fw.irq_req;
  assign o_fw.status    = s_reg.status;
  assign o_fw.ibuf      = s_reg.ibuf;
  assign o_fw.ibf_irq   = i_ibf_irq_en && s_reg.status[KHI_IBF_BIT];
  assign o_state_tick   = (s_reg.div == KHI_DIV_LAST);
  assign o_cycle_start  = (s_reg.div == 2'h0) && (s_reg.st == 3'h0);
  assign o_instr_done   = s_reg.done;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  obf_set_a: assert property (load |=> s_reg.status[KHI_OBF_BIT]
    && s_reg.obuf == $past(out_data)) else $error("output byte load lost");
  obf_clear_a: assert property (rd_obuf && !load |=> !s_reg.status[KHI_OBF_BIT])
    else $error("output full not cleared by host read");
  ibf_set_a: assert property (host_wr |=> s_reg.status[KHI_IBF_BIT]
    && s_reg.ibuf == $past(i_host.wdata)) else $error("host write not captured");
  ibf_clear_a: assert property (i_fw.ibuf_rd && !host_wr |=> !s_reg.status[KHI_IBF_BIT])
    else $error("input full not cleared");
  cmd_flag_a: assert property (host_wr |=> s_reg.status[KHI_CMD_BIT]
    == $past(i_host.addr[KHI_SEL_BIT])) else $error("command flag wrong");
  host_keeps_a: assert property (!i_fw.gp_wr && !i_fw.f0_clr && !i_fw.f0_cpl
    |=> $stable(s_reg.status[7:KHI_GP_LO]) && $stable(s_reg.status[KHI_F0_BIT]))
    else $error("general flags moved without firmware");
  stat_read_a: assert property (host_rd && i_host.addr[KHI_SEL_BIT]
    |=> o_host_rdata == $past(s_reg.status)) else $error("status read wrong");
  cycle_len_a: assert property (o_cycle_start |-> ##15 o_cycle_start)
    else $error("instruction cycle not 15 clocks");
  one_cyc_a: assert property (!s_reg.busy && i_fw.start && !i_fw.two_cyc && o_cycle_start
    |-> ##1 !o_instr_done [*8] ##7 o_instr_done) else $error("one cycle instruction timing");
  two_cyc_a: assert property (!s_reg.busy && i_fw.start && i_fw.two_cyc && o_cycle_start
    |-> ##15 !o_instr_done ##15 o_instr_done) else $error("two cycle instruction timing");
  irq_hold_a: assert property (i_irq_latch_en && i_fw.irq_req && !s_reg.irq_prev
    |=> o_host_irq || !i_irq_latch_en) else $error("latched interrupt missed");

  // Each buffer moves only on its own strobe; a stray change would corrupt a byte in flight
  obuf_read_a: assert property (rd_obuf |=> o_host_rdata == $past(s_reg.obuf))
    else $error("output byte read wrong");
  obuf_keep_a: assert property (s_reg.status[KHI_OBF_BIT] |=> $stable(s_reg.obuf))
    else $error("output byte replaced while full");
  obf_hold_a: assert property (s_reg.status[KHI_OBF_BIT] && !rd_obuf
    |=> s_reg.status[KHI_OBF_BIT]) else $error("output full dropped without read");
  ibuf_keep_a: assert property (!host_wr |=> $stable(s_reg.ibuf))
    else $error("input byte moved without host write");
  ibf_hold_a: assert property (s_reg.status[KHI_IBF_BIT] && !i_fw.ibuf_rd
    |=> s_reg.status[KHI_IBF_BIT]) else $error("input full dropped without read");
  // Flag strobes from firmware
  f0_clr_a: assert property (i_fw.f0_clr |=> !s_reg.status[KHI_F0_BIT])
    else $error("general flag zero not cleared");
  f0_cpl_a: assert property (i_fw.f0_cpl && !i_fw.f0_clr
    |=> s_reg.status[KHI_F0_BIT] != $past(s_reg.status[KHI_F0_BIT]))
    else $error("general flag zero not toggled");
  gp_write_a: assert property (i_fw.gp_wr
    |=> s_reg.status[7:KHI_GP_LO] == $past(i_fw.gp)) else $error("upper flags not written");
  // Pass mode adds no register stage, so the host sees the request in the same cycle
  irq_pass_a: assert property (!i_irq_latch_en |-> o_host_irq == i_fw.irq_req)
    else $error("passed interrupt differs from request");
  irq_drop_a: assert property (rd_obuf && !i_fw.irq_req |=> !s_reg.irq_hold)
    else $error("held interrupt survived output read");
  tick_gap_a: assert property (o_state_tick |-> ##3 o_state_tick)
    else $error("state tick not every third clock");
  start_edge_a: assert property (!s_reg.busy ##1 s_reg.busy |-> $past(o_cycle_start))
    else $error("instruction started off a cycle boundary");

  cmd_write_c: cover property (host_wr && i_host.addr[KHI_SEL_BIT]);
  one_done_c:  cover property (o_instr_done && !s_reg.second);
  fifo_full_c: cover property (!o_fw_push_ready);
  two_done_c:  cover property (o_instr_done && s_reg.second);
  irq_clr_c:   cover property (s_reg.irq_hold && rd_obuf);

endmodule // khi_host_if

// *** sim/khi_host_model.sv ***
// Host system model driving the keyboard controller host bus
`timescale 1ns/100ps
module khi_host_model (
  // Clock
  input  wire logic              i_clk,
  // Host bus
  output khi_pkg::khi_host_req_t o_host,
  output logic                   o_rd_seen
);
  import khi_pkg::*;
  initial o_host = '0;
  initial o_rd_seen = 1'b0;
  // Read data is looked at half a cycle after the taking edge
  always @(posedge i_clk) o_rd_seen <= o_host.cs & o_host.rd;
  // Released lines show the inverse, so a stale value cannot pass
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    #1;
    o_host = '{cs: 1'b1, rd: ~wr, wr: wr, addr: a, wdata: d};
    @(posedge i_clk);
    #1;
    o_host = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule // khi_host_model

// *** sim/khi_host_if_tb_top.sv ***
// Self-checking bench for the keyboard controller host interface
`timescale 1ns/100ps
module khi_host_if_tb_top;
  import khi_pkg::*;
  logic          i_clk = 1'b0;
  logic          i_sys_rst = 1'b1;
  khi_host_req_t host_req;
  logic [7:0]    host_rdata, push_data = 8'h00;
  logic          host_irq, latch_en = 1'b0, push_valid = 1'b0, push_ready;
  khi_fw_req_t   fw = '0;
  logic          ibf_en = 1'b0, rd_seen, tick, cyc_start, done;
  khi_fw_view_t  fw_view;
  int            error_cnt = 0, comparisons = 0, cyc = 0, n, t;
  logic [7:0]    exp_q[$];
  logic [7:0]    b[17];
  logic [3:0]    g;

  always #10 i_clk = ~i_clk;

  khi_host_if uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_host(host_req),
    .o_host_rdata(host_rdata), .o_host_irq(host_irq), .i_irq_latch_en(latch_en),
    .i_fw_push_valid(push_valid), .o_fw_push_ready(push_ready),
    .i_fw_push_data(push_data), .i_fw(fw), .i_ibf_irq_en(ibf_en), .o_fw(fw_view),
    .o_state_tick(tick), .o_cycle_start(cyc_start), .o_instr_done(done));
  khi_host_model host (.i_clk(i_clk), .o_host(host_req), .o_rd_seen(rd_seen));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Read answers are compared once settled, away from the edge
  always @(negedge i_clk)
    if (rd_seen === 1'b1) chk(host_rdata, exp_q.pop_front());

  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      error_cnt++;
      finish_test;
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(1'b0, a, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  task automatic fw_pulse(input int k, input logic [3:0] v);
    khi_fw_req_t r;
    r = '0;
    case (k)
      0: r.ibuf_rd = 1'b1;
      1: r.f0_cpl = 1'b1;
      2: r.f0_clr = 1'b1;
      3: {r.gp_wr, r.gp} = {1'b1, v};
      default: {r.start, r.two_cyc} = {1'b1, k[0]};
    endcase
    fw = r;
    @(posedge i_clk);
    #1;
    fw = '0;
  endtask

  task automatic push(input logic [7:0] d);
    @(posedge i_clk);
    #1;
    push_valid = 1'b1;
    push_data = d;
    // Ready is looked at between edges, where it is settled
    while (push_ready !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    #1;
    push_valid = 1'b0;
  endtask

  // Runs to the next instruction cycle boundary, counting clocks and state ticks
  task automatic to_start;
    n = 0;
    t = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      n++;
      t += int'(tick === 1'b1);
    end
    while (cyc_start !== 1'b1 && n < 40);
  endtask

  task automatic instr(input int two, input logic [7:0] e);
    to_start;
    fw_pulse(4 + two, 4'h0);
    n = 1;
    while (done !== 1'b1 && n < 40)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk(8'(n), e);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h18E5));
    repeat (6) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    ibf_en = 1'b1;
    rd(KHI_STAT_OFS, 8'h00);
    chk(8'(fw_view.ibf_irq), 8'h00);
    host.access(1'b1, KHI_DATA_OFS, 8'hA5);
    rd(KHI_STAT_OFS, 8'h02);
    chk(fw_view.ibuf, 8'hA5);
    chk(8'(fw_view.ibf_irq), 8'h01);
    fw_pulse(0, 4'h0);
    rd(KHI_STAT_OFS, 8'h00);
    host.access(1'b1, KHI_STAT_OFS, 8'h3C);
    rd(KHI_STAT_OFS, 8'h0A);
    chk(fw_view.ibuf, 8'h3C);
    fw_pulse(0, 4'h0);
    fw_pulse(1, 4'h0);
    host.access(1'b1, KHI_DATA_OFS, 8'h11);
    rd(KHI_STAT_OFS, 8'h06);
    fw_pulse(2, 4'h0);
    g = 4'($urandom);
    fw_pulse(3, g);
    host.access(1'b1, KHI_STAT_OFS, 8'hFF);
    rd(KHI_STAT_OFS, {g, 4'hA});
    chk(fw_view.status, {g, 4'hA});
    fw_pulse(0, 4'h0);
    // One byte lands in the output buffer, sixteen fill the queue
    foreach (b[i])
    begin
      b[i] = 8'($urandom);
      push(b[i]);
    end
    chk(8'(push_ready), 8'h00);
    rd(KHI_STAT_OFS, {g, 4'h9});
    foreach (b[i]) rd(KHI_DATA_OFS, b[i]);
    rd(KHI_STAT_OFS, {g, 4'h8});
    chk(8'(push_ready), 8'h01);
    latch_en = 1'b1;
    fw.irq_req = 1'b1;
    @(posedge i_clk);
    #1;
    fw.irq_req = 1'b0;
    repeat (3) @(negedge i_clk);
    chk(8'(host_irq), 8'h01);
    rd(KHI_DATA_OFS, b[16]);
    chk(8'(host_irq), 8'h00);
    latch_en = 1'b0;
    fw.irq_req = 1'b1;
    @(negedge i_clk);
    chk(8'(host_irq), 8'h01);
    @(posedge i_clk);
    #1;
    fw.irq_req = 1'b0;
    @(negedge i_clk);
    chk(8'(host_irq), 8'h00);
    // A reset in mid-run must drop both pending bytes
    host.access(1'b1, KHI_DATA_OFS, 8'h5A);
    push(8'h77);
    rd(KHI_STAT_OFS, {g, 4'h3});
    i_sys_rst = 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    i_sys_rst = 1'b0;
    rd(KHI_STAT_OFS, 8'h00);
    chk(fw_view.status, 8'h00);
    chk(8'(push_ready), 8'h01);
    instr(0, 8'h0F);
    instr(1, 8'h1E);
    to_start;
    to_start;
    chk(8'(n), 8'h0F);
    chk(8'(t), 8'h05);
    finish_test;
  end
endmodule // khi_host_if_tb_top
